// ==== rtl/gecs_pkg.sv ====
// constants and helpers shared by the gpio port with extended chip select
package gecs_pkg;

	localparam int unsigned NUM_PINS      = 7;
	localparam int unsigned MUX_LINES     = 3;
	localparam int unsigned PIN_ERR_FLAG  = 3;
	localparam int unsigned PIN_BUF_TRIG  = 4;
	localparam int unsigned PIN_BUF_ACT   = 5;
	localparam int unsigned PIN_OSC_SYNC  = 6;

	// command byte layout: 11Tx0ccc for the select command, 01Txaaaa writes
	localparam logic [1:0] CMD_XSEL_TAG   = 2'h3;
	localparam logic [1:0] CMD_WR_TAG     = 2'h1;
	localparam int unsigned CMD_T_BIT     = 5;
	localparam int unsigned CMD_ZERO_BIT  = 3;
	localparam logic [3:0] REG_GAIN_MUX   = 4'h0;
	localparam logic [2:0] PIN_CODE_NONE  = 3'h7;

	localparam logic [4:0] BIT_CMD_LAST   = 5'h07;
	localparam logic [4:0] BIT_DATA_LAST  = 5'h0f;
	localparam logic [4:0] BIT_CNT_MAX    = 5'h1f;

	localparam int unsigned CLK_NS        = 40;
	localparam int unsigned TICK_NS       = 1000;
	localparam int unsigned TICK_CYC      = (TICK_NS + CLK_NS - 1) / CLK_NS;
	localparam logic [4:0] TICK_LAST      = 5'(TICK_CYC - 1);
	localparam logic [4:0] TICK_HALF      = 5'(TICK_CYC / 2);
	localparam int unsigned BUF_TIME0_NS  = 6000;
	localparam int unsigned BUF_TIME0_CYC =
		(BUF_TIME0_NS + CLK_NS - 1) / CLK_NS;
	localparam logic [7:0] BUF_TIME0_W    = 8'(BUF_TIME0_CYC);
	localparam logic [7:0] TRIG_DELAY_TK  = 8'h03;

	localparam logic [6:0] RST_PIN_DIR    = 7'h00;
	localparam logic [2:0] RST_SYNC_CTRL  = 3'h4;
	localparam logic [6:0] RST_SYNC_PINS  = 7'h00;

	typedef enum logic [1:0] {
		GECS_HW_IDLE,
		GECS_HW_DELAY,
		GECS_HW_HOLD,
		GECS_HW_TAIL
	} gecs_hw_state_t;

	// suppression code to tick count
	function automatic logic [7:0] gecs_flag_ticks(input logic [3:0] code);
		logic [7:0] n;
		n = {4'h0, code};
		case (code)
			4'h9:    n = 8'h0c;
			4'ha:    n = 8'h10;
			4'hb:    n = 8'h18;
			4'hc:    n = 8'h20;
			4'hd:    n = 8'h30;
			4'he:    n = 8'h40;
			4'hf:    n = 8'h7f;
			default: n = {4'h0, code};
		endcase
		return n;
	endfunction : gecs_flag_ticks

endpackage : gecs_pkg

// ==== rtl/gecs_sync.sv ====
// two-flop synchroniser for a bundle of asynchronous levels
`timescale 1ns/1ns
module gecs_sync #(
	parameter int unsigned WIDTH = 1,
	parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
	input  wire logic             clk_i,
	input  wire logic             rst_n_i,
	input  wire logic [WIDTH-1:0] async_i,
	output logic      [WIDTH-1:0] sync_o
);

	logic [WIDTH-1:0] stage1;

	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			stage1 <= RESET_VAL;
			sync_o <= RESET_VAL;
		end
		else
		begin
			stage1 <= async_i;
			sync_o <= stage1;
		end
	end

endmodule : gecs_sync

// ==== rtl/gecs_port.sv ====
// seven-pin gpio port with extended chip select and buffer timing
`timescale 1ns/1ns
module gecs_port
	import gecs_pkg::*;
(
	input  wire logic       sys_clk_i,
	input  wire logic       nrst_i,
	input  wire logic       spi_sclk_i,
	input  wire logic       spi_cs_n_i,
	input  wire logic       spi_sdi_i,
	output logic            spi_sdo_o,
	output logic            spi_sdo_oe_o,
	input  wire logic [6:0] gpio_i,
	output logic      [6:0] gpio_o,
	output logic      [6:0] gpio_oe_o,
	input  wire logic [6:0] pin_direction_i,
	input  wire logic [6:0] forced_data_i,
	input  wire logic [6:0] extended_chip_select_en_i,
	input  wire logic [6:0] per_pin_clock_phase_i,
	input  wire logic       clock_phase_select_i,
	input  wire logic       oscillator_output_fn_i,
	input  wire logic       sync_clock_input_fn_i,
	input  wire logic       buffer_active_output_fn_i,
	input  wire logic       buffer_trigger_input_fn_i,
	input  wire logic       error_flag_output_fn_i,
	input  wire logic [2:0] ext_selector_line_fn_i,
	input  wire logic       buffer_active_pol_i,
	input  wire logic [3:0] buffer_on_time_i,
	input  wire logic [3:0] flag_suppression_time_i,
	input  wire logic       error_flag_i,
	output logic            buffer_active_o,
	output logic      [2:0] ext_selector_line_o,
	output logic      [6:0] gpio_level_o,
	output logic            clock_idle_level_o
);

	logic       rst_meta;
	logic       rst_n;

	always_ff @(posedge sys_clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			rst_meta <= 1'b0;
			rst_n    <= 1'b0;
		end
		else
		begin
			rst_meta <= 1'b1;
			rst_n    <= rst_meta;
		end
	end

	// link domain: runs on the serial clock; all but the event flops are cleared while deselected
	logic       link_clr;
	logic [4:0] bit_cnt;
	logic [7:0] shreg;
	logic [7:0] cmd;
	logic [7:0] byte_now;
	logic       pass;
	logic       pass_rise;
	logic [2:0] xsel_pin;
	logic       trig_tgl;
	logic       mux_tgl;
	logic [2:0] mux_word;
	logic       at_cmd_end;
	logic       at_data_end;
	logic       xsel_cmd;
	logic       xsel_ok;
	logic       wr_cmd;
	logic       trig_evt;
	logic       mux_evt;
	logic [6:0] xsel_usable;

	assign link_clr   = spi_cs_n_i | ~rst_n;
	assign byte_now   = {shreg[6:0], spi_sdi_i};
	assign xsel_usable = extended_chip_select_en_i
		& pin_direction_i;
	assign at_cmd_end  = !pass && bit_cnt == BIT_CMD_LAST;
	assign at_data_end = !pass && bit_cnt == BIT_DATA_LAST;
	assign xsel_cmd = at_cmd_end && byte_now[7:6] == CMD_XSEL_TAG
		&& !byte_now[CMD_ZERO_BIT];
	assign xsel_ok = xsel_cmd && byte_now[2:0] != PIN_CODE_NONE
		&& xsel_usable[byte_now[2:0]];
	assign wr_cmd = cmd[7:6] == CMD_WR_TAG;
	assign trig_evt = (xsel_cmd && byte_now[CMD_T_BIT])
		|| (at_data_end && wr_cmd && cmd[CMD_T_BIT]);
	assign mux_evt = at_data_end && wr_cmd && cmd[3:0] == REG_GAIN_MUX;

	// data sampled on falling edges only
	always_ff @(negedge spi_sclk_i or posedge link_clr)
	begin
		if (link_clr)
		begin
			bit_cnt <= 5'h00;
			shreg   <= 8'h00;
			cmd     <= 8'h00;
			pass    <= 1'b0;
			xsel_pin <= 3'h0;
		end
		else if (!pass)
		begin
			shreg <= byte_now;
			if (bit_cnt != BIT_CNT_MAX)
				bit_cnt <= bit_cnt + 5'h01;
			if (at_cmd_end)
				cmd <= byte_now;
			if (xsel_ok)
			begin
				pass     <= 1'b1;
				xsel_pin <= byte_now[2:0];
			end
		end
	end

	// events that outlive the frame; only the device reset clears them
	always_ff @(negedge spi_sclk_i or negedge rst_n)
	begin
		if (!rst_n)
		begin
			trig_tgl <= 1'b0;
			mux_tgl  <= 1'b0;
			mux_word <= 3'h0;
		end
		else if (!spi_cs_n_i)
		begin
			if (trig_evt)
				trig_tgl <= ~trig_tgl;
			if (mux_evt)
			begin
				mux_word <= byte_now[2:0];
				mux_tgl  <= ~mux_tgl;
			end
		end
	end

	// rising edge copy for the late select phase only
	always_ff @(posedge spi_sclk_i or posedge link_clr)
	begin
		if (link_clr)
			pass_rise <= 1'b0;
		else
			pass_rise <= pass;
	end

	// serial output changes on rising edges; read data is not served here
	always_ff @(posedge spi_sclk_i or posedge link_clr)
	begin
		if (link_clr)
			spi_sdo_o <= 1'b0;
		else
			spi_sdo_o <= 1'b0;
	end

	assign spi_sdo_oe_o = !spi_cs_n_i && !pass;

	logic       xsel_on;
	logic [6:0] xsel_low;

	// cs high clears pass at once, so the select follows it up directly
	assign xsel_on = per_pin_clock_phase_i[xsel_pin]
		? pass : pass_rise;

	always_comb
	begin
		xsel_low = 7'h00;
		if (xsel_on && xsel_pin != PIN_CODE_NONE)
			xsel_low[xsel_pin] = 1'b1;
	end

	assign clock_idle_level_o = ~clock_phase_select_i;

	// system domain
	logic [2:0] ctrl_s;
	logic [6:0] pins_s;
	logic       cs_s_d;
	logic       trig_s_d;
	logic       mux_s_d;
	logic       cs_rise;
	logic       trig_pulse;
	logic       mux_pulse;

	gecs_sync #(
		.WIDTH     (3),
		.RESET_VAL (RST_SYNC_CTRL)
	) u_sync_ctrl (
		.clk_i   (sys_clk_i),
		.rst_n_i (rst_n),
		.async_i ({spi_cs_n_i, trig_tgl, mux_tgl}),
		.sync_o  (ctrl_s)
	);

	gecs_sync #(
		.WIDTH     (7),
		.RESET_VAL (RST_SYNC_PINS)
	) u_sync_pins (
		.clk_i   (sys_clk_i),
		.rst_n_i (rst_n),
		.async_i (gpio_i),
		.sync_o  (pins_s)
	);

	always_ff @(posedge sys_clk_i or negedge rst_n)
	begin
		if (!rst_n)
		begin
			cs_s_d   <= 1'b1;
			trig_s_d <= 1'b0;
			mux_s_d  <= 1'b0;
		end
		else
		begin
			cs_s_d   <= ctrl_s[2];
			trig_s_d <= ctrl_s[1];
			mux_s_d  <= ctrl_s[0];
		end
	end

	assign cs_rise    = ctrl_s[2] && !cs_s_d;
	assign trig_pulse = ctrl_s[1] ^ trig_s_d;
	assign mux_pulse  = ctrl_s[0] ^ mux_s_d;

	// selector lines wait for the end of the frame
	logic       mux_pend;
	logic [2:0] mux_addr;

	always_ff @(posedge sys_clk_i or negedge rst_n)
	begin
		if (!rst_n)
		begin
			mux_pend <= 1'b0;
			mux_addr <= 3'h0;
		end
		else if (mux_pend && ctrl_s[2])
		begin
			mux_pend <= mux_pulse;
			mux_addr <= mux_word;
		end
		else if (mux_pulse)
			mux_pend <= 1'b1;
	end

	// internal 1 MHz tick, or the sync pin when routed
	logic [4:0] tick_cnt;
	logic       osc;
	logic       sync_d;
	logic       sync_sel;
	logic       tick;

	assign sync_sel = sync_clock_input_fn_i
		&& !pin_direction_i[PIN_OSC_SYNC];

	always_ff @(posedge sys_clk_i or negedge rst_n)
	begin
		if (!rst_n)
		begin
			tick_cnt <= 5'h00;
			osc      <= 1'b0;
			sync_d   <= 1'b0;
		end
		else
		begin
			tick_cnt <= (tick_cnt == TICK_LAST) ? 5'h00 : tick_cnt + 5'h01;
			osc      <= tick_cnt < TICK_HALF;
			sync_d   <= pins_s[PIN_OSC_SYNC];
		end
	end

	assign tick = sync_sel ? (pins_s[PIN_OSC_SYNC] && !sync_d)
		: tick_cnt == TICK_LAST;

	// software started buffer
	logic        sw_hold;
	logic [11:0] sw_cnt;
	logic [11:0] on_cycles;

	// each on-time step adds one shortest period
	assign on_cycles = 12'(BUF_TIME0_W) * ({8'h00, buffer_on_time_i}
		+ 12'h001);

	always_ff @(posedge sys_clk_i or negedge rst_n)
	begin
		if (!rst_n)
		begin
			sw_hold <= 1'b0;
			sw_cnt  <= 12'h000;
		end
		else if (trig_pulse && ctrl_s[2])
		begin
			sw_hold <= 1'b0;
			sw_cnt  <= on_cycles;
		end
		else if (trig_pulse)
			sw_hold <= 1'b1;
		else if (sw_hold && cs_rise)
		begin
			sw_hold <= 1'b0;
			sw_cnt  <= on_cycles;
		end
		else if (sw_cnt != 12'h000)
			sw_cnt <= sw_cnt - 12'h001;
	end

	// external trigger on pin four
	gecs_hw_state_t hw_state;
	logic [7:0]     hw_cnt;
	logic           trig_in;
	logic           trig_d;
	logic           hw_active;

	assign trig_in = buffer_trigger_input_fn_i
		&& !pin_direction_i[PIN_BUF_TRIG] && pins_s[PIN_BUF_TRIG];

	always_ff @(posedge sys_clk_i or negedge rst_n)
	begin
		if (!rst_n)
		begin
			hw_state <= GECS_HW_IDLE;
			hw_cnt   <= 8'h00;
			trig_d   <= 1'b0;
		end
		else
		begin
			trig_d <= trig_in;
			case (hw_state)
				GECS_HW_IDLE:
					if (trig_in && !trig_d)
					begin
						hw_state <= GECS_HW_DELAY;
						hw_cnt   <= TRIG_DELAY_TK;
					end
				GECS_HW_DELAY:
					if (tick)
					begin
						// the partial first tick is not counted, so 3 to 4 ticks
						if (hw_cnt == 8'h00)
							hw_state <= GECS_HW_HOLD;
						else
							hw_cnt <= hw_cnt - 8'h01;
					end
				GECS_HW_HOLD:
					if (!trig_in)
					begin
						hw_state <= GECS_HW_TAIL;
						hw_cnt   <= TRIG_DELAY_TK
							+ gecs_flag_ticks(flag_suppression_time_i);
					end
				GECS_HW_TAIL:
					if (trig_in)
						hw_state <= GECS_HW_HOLD;
					else if (tick)
					begin
						if (hw_cnt == 8'h00)
							hw_state <= GECS_HW_IDLE;
						else
							hw_cnt <= hw_cnt - 8'h01;
					end
				default:
					hw_state <= GECS_HW_IDLE;
			endcase
		end
	end

	assign hw_active = hw_state == GECS_HW_HOLD
		|| hw_state == GECS_HW_TAIL;

	logic buf_act;

	assign buf_act = sw_hold || sw_cnt != 12'h000 || hw_active;

	// pin output stage
	logic [6:0] dir_q;
	logic [6:0] pin_q;
	logic [6:0] next_pin;

	always_comb
	begin
		next_pin = ~forced_data_i;
		for (int i = 0; i < MUX_LINES; i++)
			if (ext_selector_line_fn_i[i])
				next_pin[i] = mux_addr[i];
		if (error_flag_output_fn_i)
			next_pin[PIN_ERR_FLAG] = error_flag_i;
		if (buffer_active_output_fn_i)
			next_pin[PIN_BUF_ACT] = buf_act ^ buffer_active_pol_i;
		if (oscillator_output_fn_i)
			next_pin[PIN_OSC_SYNC] = osc;
	end

	always_ff @(posedge sys_clk_i or negedge rst_n)
	begin
		if (!rst_n)
		begin
			dir_q           <= RST_PIN_DIR;
			pin_q           <= 7'h7f;
			buffer_active_o <= 1'b0;
			gpio_level_o    <= 7'h00;
		end
		else
		begin
			dir_q           <= pin_direction_i;
			pin_q           <= next_pin;
			buffer_active_o <= buf_act;
			gpio_level_o    <= (pin_direction_i & ~forced_data_i)
				| (~pin_direction_i & pins_s);
		end
	end

	assign ext_selector_line_o = mux_addr;
	assign gpio_oe_o = dir_q;

	// select pins bypass the register to keep serial timing tight
	always_comb
	begin
		for (int i = 0; i < NUM_PINS; i++)
			gpio_o[i] = (xsel_usable[i] && dir_q[i]) ? !xsel_low[i]
				: pin_q[i];
	end

endmodule : gecs_port

// ==== verif/gecs_props.sv ====
// concurrent checks on the ports of the gpio port
`timescale 1ns/1ns
module gecs_props (
	input wire logic       sys_clk_i,
	input wire logic       nrst_i,
	input wire logic       spi_cs_n_i,
	input wire logic       spi_sdo_oe_o,
	input wire logic [6:0] gpio_i,
	input wire logic [6:0] gpio_o,
	input wire logic [6:0] gpio_oe_o,
	input wire logic [6:0] pin_direction_i,
	input wire logic [6:0] extended_chip_select_en_i,
	input wire logic       clock_phase_select_i,
	input wire logic       buffer_trigger_input_fn_i,
	input wire logic [3:0] buffer_on_time_i,
	input wire logic       buffer_active_o,
	input wire logic [2:0] ext_selector_line_o,
	input wire logic       clock_idle_level_o
);
	logic [6:0] xsel_m;

	// both the request and the applied direction, so a lag cannot misfire
	assign xsel_m = extended_chip_select_en_i & pin_direction_i & gpio_oe_o;

	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (!nrst_i);

	property p_dir;
		$changed(pin_direction_i) |-> ##[1:3] gpio_oe_o == pin_direction_i;
	endproperty
	a_dir: assert property (p_dir)
		else $error("direction not applied");
	property p_rst;
		disable iff (1'b0) !nrst_i |-> gpio_oe_o == 7'h00;
	endproperty
	a_rst: assert property (p_rst)
		else $error("pin driven in reset");
	property p_xsel; spi_cs_n_i |-> (gpio_o & xsel_m) == xsel_m; endproperty
	a_xsel: assert property (p_xsel)
		else $error("select low while deselected");
	property p_sdo; spi_cs_n_i |-> !spi_sdo_oe_o; endproperty
	a_sdo: assert property (p_sdo)
		else $error("data out driven while deselected");
	property p_idle; clock_idle_level_o == !clock_phase_select_i; endproperty
	a_idle: assert property (p_idle)
		else $error("idle level wrong");
	property p_sel; !spi_cs_n_i [*4] |-> $stable(ext_selector_line_o); endproperty
	a_sel: assert property (p_sel)
		else $error("selector moved in a frame");
	property p_buf;
		$rose(spi_cs_n_i) && buffer_active_o && buffer_on_time_i == 4'h0
			&& !buffer_trigger_input_fn_i
			|-> ##140 buffer_active_o ##[5:20] !buffer_active_o;
	endproperty
	a_buf: assert property (p_buf)
		else $error("buffer time wrong");
	property p_trig;
		$rose(gpio_i[4]) && buffer_trigger_input_fn_i && !pin_direction_i[4]
			&& !buffer_active_o |-> ##70 !buffer_active_o ##[3:40] buffer_active_o;
	endproperty
	a_trig: assert property (p_trig)
		else $error("trigger delay wrong");
endmodule : gecs_props

bind gecs_port gecs_props gecs_props_i (
	.sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .spi_cs_n_i(spi_cs_n_i),
	.spi_sdo_oe_o(spi_sdo_oe_o), .gpio_i(gpio_i), .gpio_o(gpio_o),
	.gpio_oe_o(gpio_oe_o), .pin_direction_i(pin_direction_i),
	.extended_chip_select_en_i(extended_chip_select_en_i),
	.clock_phase_select_i(clock_phase_select_i),
	.buffer_trigger_input_fn_i(buffer_trigger_input_fn_i),
	.buffer_on_time_i(buffer_on_time_i), .buffer_active_o(buffer_active_o),
	.ext_selector_line_o(ext_selector_line_o),
	.clock_idle_level_o(clock_idle_level_o)
);

// ==== verif/gecs_spi_master.sv ====
// behavioural serial master on the link side of the port
`timescale 1ns/1ns
module gecs_spi_master (
	output logic sclk_o = 1'b1,
	output logic cs_n_o = 1'b1,
	output logic sdi_o  = 1'b0
);
	int half = 32;

	task automatic sel();
		#7;
		cs_n_o = 1'b0;
		#(half);
	endtask : sel

	// leaves the clock low after the last falling edge so the bench can
	// look between the two edges
	task automatic shift(input logic [15:0] d, input int n);
		for (int i = n - 1; i >= 0; i--)
		begin
			if (sclk_o == 1'b0)
				rise();
			sdi_o = d[i];
			#(half);
			sclk_o = 1'b0;
		end
	endtask : shift

	task automatic rise();
		#(half);
		sclk_o = 1'b1;
	endtask : rise

	// data no longer held once deselected, so it is turned over
	task automatic desel();
		if (sclk_o == 1'b0)
			rise();
		#160;
		cs_n_o = 1'b1;
		sdi_o = ~sdi_o;
	endtask : desel
endmodule : gecs_spi_master

// ==== verif/tb.sv ====
// self-checking bench for the gpio port with extended chip select
`timescale 1ns/1ns
module tb;
	// reset starts unknown so that its first fall is an edge the flops see
	logic       clk = 1'b0, nrst, phase_sel = 1'b0;
	logic       sclk, cs_n, sdi, sdo, sdo_oe, ba, idle;
	logic       ba_fn = 1'b0, trig_fn = 1'b0;
	logic [6:0] gpio_out, gpio_oe, level, pins_in = 7'h00;
	logic [6:0] dir = 7'h00, forced = 7'h00, xsel_en = 7'h00, phase = 7'h00;
	logic [3:0] on_time = 4'h0, flag_time = 4'h0;
	logic [2:0] sel_fn = 3'h0, sel_lines, last_mux = 3'h0;
	int         err_count = 0;
	int         n_tests = 0;

	always #20 clk = ~clk;

	gecs_spi_master gecs_spi_master_i (
		.sclk_o(sclk), .cs_n_o(cs_n), .sdi_o(sdi)
	);

	gecs_port gecs_port_i (
		.sys_clk_i(clk), .nrst_i(nrst), .spi_sclk_i(sclk),
		.spi_cs_n_i(cs_n), .spi_sdi_i(sdi), .spi_sdo_o(sdo),
		.spi_sdo_oe_o(sdo_oe), .gpio_i(pins_in), .gpio_o(gpio_out),
		.gpio_oe_o(gpio_oe), .pin_direction_i(dir),
		.forced_data_i(forced), .extended_chip_select_en_i(xsel_en),
		.per_pin_clock_phase_i(phase), .clock_phase_select_i(phase_sel),
		.oscillator_output_fn_i(1'b0), .sync_clock_input_fn_i(1'b0),
		.buffer_active_output_fn_i(ba_fn),
		.buffer_trigger_input_fn_i(trig_fn),
		.error_flag_output_fn_i(1'b0), .ext_selector_line_fn_i(sel_fn),
		.buffer_active_pol_i(1'b0), .buffer_on_time_i(on_time),
		.flag_suppression_time_i(flag_time), .error_flag_i(1'b0),
		.buffer_active_o(ba), .ext_selector_line_o(sel_lines),
		.gpio_level_o(level), .clock_idle_level_o(idle)
	);

	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask : cyc

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			err_count++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : complete_run

	// counts settled cycles until buffer active reaches lvl
	task automatic ba_wait(input logic lvl, input int lim, output int n);
		n = 0;
		while (ba !== lvl && n < lim)
		begin
			@(negedge clk);
			n++;
		end
		if (ba !== lvl)
		begin
			chk(ba, lvl);
			complete_run();
		end
	endtask : ba_wait

	task automatic t_plain();
		chk({gpio_oe, gpio_out, ba}, {7'h00, 7'h7f, 1'b0});
		cyc(1);
		phase_sel <= 1'b1;
		forced <= 7'h05;
		cyc(2);
		dir <= 7'h7f;
		cyc(4);
		@(negedge clk);
		chk({gpio_oe, gpio_out, idle}, {7'h7f, 7'h7a, 1'b0});
		cyc(1);
		phase_sel <= 1'b0;
		sel_fn <= 3'h1;
		dir <= 7'h7b;
		cyc(2);
		forced <= 7'h01;
		cyc(2);
		@(negedge clk);
		chk(gpio_oe, 7'h7b);
		cyc(1);
		sel_fn <= 3'h0;
		dir <= 7'h7f;
		cyc(3);
		@(negedge clk);
		chk(gpio_out, 7'h7e);
	endtask : t_plain

	task automatic t_xsel(input logic ph, input logic [7:0] cmd);
		cyc(1);
		forced <= 7'h00;
		xsel_en <= 7'h06;
		phase <= {5'h00, ph, ph};
		cyc(3);
		gecs_spi_master_i.half = 64;
		gecs_spi_master_i.sel();
		gecs_spi_master_i.shift({8'h00, cmd}, 8);
		#4;
		chk(gpio_out[1], !ph);
		gecs_spi_master_i.rise();
		#4;
		chk({sdo_oe, gpio_out[2:1]}, 3'h2);
		gecs_spi_master_i.shift(16'h00c2, 8);
		gecs_spi_master_i.rise();
		#4;
		chk({sdo_oe, gpio_out[2:1]}, 3'h2);
		gecs_spi_master_i.desel();
		#4;
		chk({sdo_oe, gpio_out[2:1]}, 3'h3);
	endtask : t_xsel

	task automatic t_refuse();
		logic [7:0] cmds [3] = '{8'hc3, 8'hc4, 8'hc7};
		cyc(1);
		xsel_en <= 7'h10;
		dir <= 7'h6f;
		foreach (cmds[i])
		begin
			cyc(3);
			gecs_spi_master_i.sel();
			gecs_spi_master_i.shift({8'h00, cmds[i]}, 8);
			gecs_spi_master_i.rise();
			#4;
			chk({sdo_oe, sdo, gpio_out | 7'h10}, 9'h17f);
			gecs_spi_master_i.desel();
		end
		chk(gpio_oe, 7'h6f);
	endtask : t_refuse

	task automatic t_buf(input logic [3:0] code, input logic [2:0] mux);
		int n;
		cyc(1);
		on_time <= code;
		ba_fn <= 1'b1;
		sel_fn <= 3'h7;
		xsel_en <= 7'h00;
		dir <= 7'h7f;
		cyc(3);
		gecs_spi_master_i.half = 32;
		gecs_spi_master_i.sel();
		gecs_spi_master_i.shift({8'h60, 5'h00, mux}, 16);
		ba_wait(1'b1, 10, n);
		chk({gpio_out[5], sel_lines}, {1'b1, last_mux});
		gecs_spi_master_i.desel();
		ba_wait(1'b0, 2000, n);
		chk(n >= 150 * (code + 1) && n <= 150 * (code + 1) + 8, 1);
		chk({gpio_out[5], gpio_out[2:0], sel_lines}, {1'b0, mux, mux});
		last_mux = mux;
	endtask : t_buf

	task automatic t_trig();
		int n;
		cyc(1);
		dir <= 7'h6f;
		trig_fn <= 1'b1;
		flag_time <= 4'h9;
		cyc(3);
		pins_in <= 7'h10;
		ba_wait(1'b1, 150, n);
		chk(n >= 75 && n <= 110, 1'b1);
		cyc(250);
		@(negedge clk);
		chk({ba, gpio_out[5]}, 2'h3);
		chk(level, 7'h7f);
		cyc(1);
		pins_in <= 7'h00;
		ba_wait(1'b0, 600, n);
		chk(n >= 375 && n <= 415, 1'b1);
		chk(level, 7'h6f);
	endtask : t_trig

	initial
	begin
		nrst <= 1'b0;
		cyc(20);
		nrst <= 1'b1;
		cyc(4);
		@(negedge clk);
		t_plain();
		t_xsel(1'b1, 8'hc1);
		t_xsel(1'b0, 8'hd1);
		t_refuse();
		t_buf(4'h0, 3'h5);
		t_buf(4'h1, 3'h2);
		t_trig();
		complete_run();
	end
endmodule : tb
